//--- rtl/wts_pkg.sv
// constants of the watch timer: register map, field positions, reset values, counts
// assumes a 32-bit classic wishbone bus on a 200 MHz clock that also serves as the master clock
// Summary of operation
// - 32-bit counter advances once per slow tick, from oscillator or master clock divided by 64
// - counter returns to zero at the 24-hour or full-range limit chosen in wrap_mode
// - seconds_count writes are taken only while the counter is disabled
// - 32-bit alarm value at the same tick resolution as the counter
// - alarm event raised at the end of the tick period where count equals alarm
// - alarm_compare writes are taken only while the alarm is disabled
// - in 24-hour mode an alarm write at or above the day limit is dropped
// - enable and disable complete after a crossing delay, confirmed by events
// - each CAN frame end copies the live count into that channel's time stamp
// - writing one to soft_reset_cmd resets the whole timer; zero does nothing
// - count is the number of ticks since last cleared by wrap or reset, or the loaded value plus the ticks since a load
// - wrap bit zero clears after 0xA8BFFFFF; bit one clears after 0x0FFFFFFF
// - enable and disable set together in one write act as disable
// - each event flag stays set until software writes one to its clear bit
// - count_write_busy reads one while a count load is still crossing over
package wts_pkg;
    localparam logic [31:0] ADR_CONTROL = 32'hFFFA_4060;
    localparam logic [31:0] ADR_MODE = 32'hFFFA_4064;
    localparam logic [31:0] ADR_CLEAR = 32'hFFFA_406C;
    localparam logic [31:0] ADR_STATUS = 32'hFFFA_4070;
    localparam logic [31:0] ADR_IER = 32'hFFFA_4074;
    localparam logic [31:0] ADR_IDR = 32'hFFFA_4078;
    localparam logic [31:0] ADR_IMR = 32'hFFFA_407C;
    localparam logic [31:0] ADR_SECS = 32'hFFFA_4080;
    localparam logic [31:0] ADR_ALARM = 32'hFFFA_4084;
    // control_cmd bits
    localparam int CTL_SOFT_RESET = 0;
    localparam int CTL_CNT_ON = 1;
    localparam int CTL_CNT_OFF = 2;
    localparam int CTL_ALM_ON = 3;
    localparam int CTL_ALM_OFF = 4;
    // event flags, shared by event_clear, event_status, irq mask registers
    localparam int EV_ALARM = 0;
    localparam int EV_CNT_ON = 1;
    localparam int EV_CNT_OFF = 2;
    localparam int EV_ALM_ON = 3;
    localparam int EV_ALM_OFF = 4;
    localparam int EV_NUM = 5;
    localparam int ST_WRITE_BUSY = 5;
    localparam int ST_CNT_ENABLED = 8;
    localparam int ST_ALM_ENABLED = 9;
    // wrap_mode bits
    localparam int MODE_WRAP_SEL = 0;
    localparam int MODE_TICK_SRC = 1;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_MASK = 32'h0000_0003;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] ALARM_RESET = 32'h0000_0000;
    localparam logic [31:0] LIMIT_DAY = 32'hA8C0_0000;
    localparam logic [31:0] LAST_DAY = 32'hA8BF_FFFF;
    localparam logic [31:0] LAST_FULL = 32'h0FFF_FFFF;
    localparam logic [5:0] MCK_DIV_LAST = 6'h3F;
    localparam int CAN_CHANNELS = 16;
    // command slots carried by the handshake
    localparam int CMD_CNT_ON = 0;
    localparam int CMD_CNT_OFF = 1;
    localparam int CMD_ALM_ON = 2;
    localparam int CMD_ALM_OFF = 3;
    localparam int CMD_LOAD = 4;
    localparam int CMD_NUM = 5;
endpackage

//--- rtl/wts_watch_timer.sv
// watch timer: seconds counter, alarm comparator, CAN time stamp feed, wishbone register slave
// assumes a single clk_i that is the master clock; the oscillator arrives on a pin, unsynchronised
`timescale 1ns/100ps
module wts_watch_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic rt_oscillator_clock_i,
    input wire logic [wts_pkg::CAN_CHANNELS-1:0] can_frame_done_i,
    output logic [wts_pkg::CAN_CHANNELS-1:0] can_stamp_we_o,
    output logic [31:0] can_stamp_o
);
    localparam int EV_NUM_W = wts_pkg::EV_NUM;
    logic ack_q;
    logic [31:0] rdata_q;
    logic srst_q;
    logic rst_all;
    logic [31:0] mode_q;
    logic [EV_NUM_W-1:0] flags_q;
    logic [EV_NUM_W-1:0] mask_q;
    logic irq_q;
    logic [31:0] count_q;
    logic [31:0] alarm_q;
    logic [31:0] load_val_q;
    logic cnt_en_q;
    logic alm_en_q;
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic [5:0] div_q;
    logic tick;
    logic [wts_pkg::CMD_NUM-1:0] pend_q;
    logic [wts_pkg::CMD_NUM-1:0] flight_q;
    logic req_tgl_q;
    logic req_s1_q;
    logic req_s2_q;
    logic ack_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic in_flight_q;
    logic busy;
    logic launch;
    logic apply;
    logic done;
    logic acc;
    logic wr;
    logic [31:0] bmask;
    logic [31:0] wdat;
    logic [31:0] status;
    logic [31:0] alm_new;
    logic [31:0] cnt_last;
    logic alarm_hit;
    logic [EV_NUM_W-1:0] ev_set;
    logic [EV_NUM_W-1:0] ev_clr;
    logic [wts_pkg::CAN_CHANNELS-1:0] stamp_we_q;
    logic [31:0] stamp_q;

    // bus access decode; the register write happens at the same edge that raises ack
    assign acc = cyc_i && stb_i && !ack_q;
    assign wr = acc && we_i;
    assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wdat = dat_i & bmask;
    assign rst_all = rst_i || srst_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    // soft reset is a one-cycle pulse; the bus handshake itself is spared so the write is acked
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            srst_q <= 1'b0;
        end else begin
            srst_q <= wr && (adr_i == wts_pkg::ADR_CONTROL)
                      && wdat[wts_pkg::CTL_SOFT_RESET];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            mode_q <= wts_pkg::MODE_RESET;
        end else if (wr && adr_i == wts_pkg::ADR_MODE) begin
            mode_q <= ((mode_q & ~bmask) | wdat) & wts_pkg::MODE_MASK;
        end
    end

    // slow tick: oscillator edge after two-flop sync, or master clock divided by 64
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            div_q <= 6'h00;
        end else begin
            osc_s1_q <= rt_oscillator_clock_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            div_q <= div_q + 6'h01;
        end
    end
    assign tick = mode_q[wts_pkg::MODE_TICK_SRC] ? (div_q == wts_pkg::MCK_DIV_LAST)
                                                  : (osc_s2_q && !osc_s3_q);

    // command gathering; off overrides on, in the same write and against an older pending on
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            pend_q <= '0;
            load_val_q <= wts_pkg::COUNT_RESET;
        end else begin
            if (launch) begin
                pend_q <= '0;
            end
            if (wr && adr_i == wts_pkg::ADR_CONTROL) begin
                if (wdat[wts_pkg::CTL_CNT_OFF]) begin
                    pend_q[wts_pkg::CMD_CNT_OFF] <= 1'b1;
                    pend_q[wts_pkg::CMD_CNT_ON] <= 1'b0;
                end else if (wdat[wts_pkg::CTL_CNT_ON]) begin
                    pend_q[wts_pkg::CMD_CNT_ON] <= 1'b1;
                    pend_q[wts_pkg::CMD_CNT_OFF] <= 1'b0;
                end
                if (wdat[wts_pkg::CTL_ALM_OFF]) begin
                    pend_q[wts_pkg::CMD_ALM_OFF] <= 1'b1;
                    pend_q[wts_pkg::CMD_ALM_ON] <= 1'b0;
                end else if (wdat[wts_pkg::CTL_ALM_ON]) begin
                    pend_q[wts_pkg::CMD_ALM_ON] <= 1'b1;
                    pend_q[wts_pkg::CMD_ALM_OFF] <= 1'b0;
                end
            end
            // a load is refused while the counter runs; it could tear against a tick
            if (wr && adr_i == wts_pkg::ADR_SECS && !cnt_en_q) begin
                pend_q[wts_pkg::CMD_LOAD] <= 1'b1;
                load_val_q <= (load_val_q & ~bmask) | wdat;
            end
        end
    end

    // toggle handshake toward the tick side and back; one command set in flight at a time
    // commands written meanwhile wait in pend_q and leave together at the next launch
    assign busy = req_tgl_q != ack_s2_q;
    assign launch = !busy && !in_flight_q && (pend_q != '0);
    assign apply = req_s2_q != ack_tgl_q;
    assign done = in_flight_q && !busy;

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            req_tgl_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            in_flight_q <= 1'b0;
            flight_q <= '0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            ack_tgl_q <= req_s2_q;
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            if (launch) begin
                req_tgl_q <= !req_tgl_q;
                flight_q <= pend_q;
                in_flight_q <= 1'b1;
            end else if (done) begin
                in_flight_q <= 1'b0;
            end
        end
    end

    // tick side: enables and count loads move only when the handshake delivers
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            cnt_en_q <= 1'b0;
            alm_en_q <= 1'b0;
        end else if (apply) begin
            if (flight_q[wts_pkg::CMD_CNT_OFF]) begin
                cnt_en_q <= 1'b0;
            end else if (flight_q[wts_pkg::CMD_CNT_ON]) begin
                cnt_en_q <= 1'b1;
            end
            if (flight_q[wts_pkg::CMD_ALM_OFF]) begin
                alm_en_q <= 1'b0;
            end else if (flight_q[wts_pkg::CMD_ALM_ON]) begin
                alm_en_q <= 1'b1;
            end
        end
    end

    assign cnt_last = mode_q[wts_pkg::MODE_WRAP_SEL] ? wts_pkg::LAST_FULL : wts_pkg::LAST_DAY;

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            count_q <= wts_pkg::COUNT_RESET;
        end else if (apply && flight_q[wts_pkg::CMD_LOAD]) begin
            // a load outranks a tick landing in the same cycle
            count_q <= load_val_q;
        end else if (tick && cnt_en_q) begin
            if (count_q == cnt_last) begin
                count_q <= wts_pkg::COUNT_RESET;
            end else begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    // a value at or above the day limit would never match in 24-hour mode, so it is dropped
    assign alm_new = (alarm_q & ~bmask) | wdat;
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            alarm_q <= wts_pkg::ALARM_RESET;
        end else if (wr && adr_i == wts_pkg::ADR_ALARM && !alm_en_q) begin
            if (mode_q[wts_pkg::MODE_WRAP_SEL] || alm_new < wts_pkg::LIMIT_DAY) begin
                alarm_q <= alm_new;
            end
        end
    end

    // the match is judged at the tick that closes the period holding the value
    assign alarm_hit = tick && cnt_en_q && alm_en_q && (count_q == alarm_q);

    always_comb begin
        ev_set = '0;
        ev_set[wts_pkg::EV_ALARM] = alarm_hit;
        ev_set[wts_pkg::EV_CNT_ON] = done && flight_q[wts_pkg::CMD_CNT_ON];
        ev_set[wts_pkg::EV_CNT_OFF] = done && flight_q[wts_pkg::CMD_CNT_OFF];
        ev_set[wts_pkg::EV_ALM_ON] = done && flight_q[wts_pkg::CMD_ALM_ON];
        ev_set[wts_pkg::EV_ALM_OFF] = done && flight_q[wts_pkg::CMD_ALM_OFF];
        ev_clr = '0;
        if (wr && adr_i == wts_pkg::ADR_CLEAR) begin
            ev_clr = wdat[EV_NUM_W-1:0];
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            mask_q <= '0;
        end else if (wr && adr_i == wts_pkg::ADR_IER) begin
            mask_q <= mask_q | wdat[EV_NUM_W-1:0];
        end else if (wr && adr_i == wts_pkg::ADR_IDR) begin
            mask_q <= mask_q & ~wdat[EV_NUM_W-1:0];
        end
    end

    // registered so the pin cannot glitch; it trails the flags by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & mask_q);
        end
    end

    always_comb begin
        status = '0;
        status[EV_NUM_W-1:0] = flags_q;
        status[wts_pkg::ST_WRITE_BUSY] = pend_q[wts_pkg::CMD_LOAD]
                                       || (in_flight_q && flight_q[wts_pkg::CMD_LOAD]);
        status[wts_pkg::ST_CNT_ENABLED] = cnt_en_q;
        status[wts_pkg::ST_ALM_ENABLED] = alm_en_q;
    end

    // count lives on this clock, so a read always returns one consistent word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc && !we_i) begin
            // unmapped and write-only places read as zero
            unique case (adr_i)
                wts_pkg::ADR_MODE: rdata_q <= mode_q;
                wts_pkg::ADR_STATUS: rdata_q <= status;
                wts_pkg::ADR_IMR: rdata_q <= {27'h000_0000, mask_q};
                wts_pkg::ADR_SECS: rdata_q <= count_q;
                wts_pkg::ADR_ALARM: rdata_q <= alarm_q;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // time stamp per CAN channel, one-cycle write strobe with the live count
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            stamp_we_q <= '0;
            stamp_q <= wts_pkg::COUNT_RESET;
        end else begin
            stamp_we_q <= can_frame_done_i;
            if (|can_frame_done_i) begin
                stamp_q <= count_q;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;
    assign irq_o = irq_q;
    assign can_stamp_we_o = stamp_we_q;
    assign can_stamp_o = stamp_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || srst_q);

    AST_INC: assert property (tick && cnt_en_q && !apply && count_q != cnt_last
        |=> count_q == $past(count_q) + 32'h0000_0001) else $error("count did not step");
    AST_WRAP: assert property (tick && cnt_en_q && !apply && count_q == cnt_last
        |=> count_q == 32'h0000_0000) else $error("count did not wrap");
    AST_ALARM: assert property (alarm_hit |=> flags_q[wts_pkg::EV_ALARM])
        else $error("alarm flag missing");
    AST_ALM_REJECT: assert property (wr && adr_i == wts_pkg::ADR_ALARM
        && !mode_q[wts_pkg::MODE_WRAP_SEL] && alm_new >= wts_pkg::LIMIT_DAY
        |=> $stable(alarm_q)) else $error("out of range alarm stored");
    AST_ALM_LOCK: assert property (wr && adr_i == wts_pkg::ADR_ALARM && alm_en_q
        |=> $stable(alarm_q)) else $error("alarm changed while enabled");
    AST_SECS_LOCK: assert property (wr && adr_i == wts_pkg::ADR_SECS && cnt_en_q
        && !pend_q[wts_pkg::CMD_LOAD] && !launch |=> !pend_q[wts_pkg::CMD_LOAD])
        else $error("load taken while counting");
    AST_BOTH_OFF: assert property (wr && adr_i == wts_pkg::ADR_CONTROL
        && wdat[wts_pkg::CTL_CNT_ON] && wdat[wts_pkg::CTL_CNT_OFF]
        |=> pend_q[wts_pkg::CMD_CNT_OFF] && !pend_q[wts_pkg::CMD_CNT_ON])
        else $error("both bits not taken as off");
    AST_CONFIRM: assert property (launch && pend_q[wts_pkg::CMD_CNT_ON]
        |-> ##7 flags_q[wts_pkg::EV_CNT_ON] && cnt_en_q) else $error("no enable event");
    AST_STICKY: assert property (flags_q[wts_pkg::EV_ALARM] && !ev_clr[wts_pkg::EV_ALARM]
        |=> flags_q[wts_pkg::EV_ALARM]) else $error("flag lost");
    AST_BUSY: assert property (wr && adr_i == wts_pkg::ADR_SECS && !cnt_en_q
        |=> status[wts_pkg::ST_WRITE_BUSY] [*2]) else $error("busy flag missing");
    AST_IRQ: assert property (|(flags_q & mask_q) |=> irq_o)
        else $error("interrupt not raised");
    AST_STAMP: assert property (can_frame_done_i[0]
        |=> can_stamp_we_o[0] && can_stamp_o == $past(count_q)) else $error("bad stamp");
    AST_SRST: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && adr_i == wts_pkg::ADR_CONTROL && wdat[wts_pkg::CTL_SOFT_RESET] && !srst_q
        |-> ##2 count_q == 32'h0000_0000 && mask_q == '0 && !cnt_en_q)
        else $error("soft reset incomplete");

    // command effects land a fixed number of cycles after launch
    AST_LOAD: assert property (apply && flight_q[wts_pkg::CMD_LOAD]
        |=> count_q == $past(load_val_q)) else $error("load value not taken");
    AST_CNT_OFF: assert property (launch && pend_q[wts_pkg::CMD_CNT_OFF]
        |-> ##4 !cnt_en_q) else $error("counter not disabled");
    // the count and the stamp stay put when nothing may move them, and the pin is low the cycle after no masked flag is set
    AST_HOLD: assert property (!cnt_en_q && !apply |=> $stable(count_q))
        else $error("count moved while disabled");
    AST_IRQ_LOW: assert property (!(|(flags_q & mask_q)) |=> !irq_o)
        else $error("interrupt without masked flag");
    AST_STAMP_HOLD: assert property (!(|can_frame_done_i) |=> $stable(can_stamp_o))
        else $error("stamp changed without frame");

    CVR_WRAP: cover property (tick && cnt_en_q && count_q == cnt_last);
    CVR_ALARM: cover property (alarm_hit ##1 irq_o);
    CVR_STAMP: cover property (|can_frame_done_i && cnt_en_q);
    CVR_LOAD: cover property (apply && flight_q[wts_pkg::CMD_LOAD]);
    CVR_OSC: cover property (tick && !mode_q[wts_pkg::MODE_TICK_SRC] && cnt_en_q);
endmodule // wts_watch_timer

//--- tb/wts_watch_timer_tb.sv
// self-checking bench for the watch timer: register bus, counter, alarm, irq, CAN stamps
// assumes the design acks every access one cycle after it is taken, as the hand-over states
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module wts_watch_timer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h0000_0000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic rt_oscillator_clock_i = 1'b0;
    logic [15:0] can_frame_done_i = 16'h0000;
    logic [15:0] can_stamp_we_o;
    logic [31:0] can_stamp_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc_cnt = 0;
    logic [31:0] q;
    logic [31:0] last;
    logic [3:0] be = 4'hF;

    always #2.5 clk_i = ~clk_i;

    wts_watch_timer u_wts_watch_timer (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .rt_oscillator_clock_i(rt_oscillator_clock_i),
        .can_frame_done_i(can_frame_done_i), .can_stamp_we_o(can_stamp_we_o),
        .can_stamp_o(can_stamp_o)
    );

    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hang anywhere ends the run through the same verdict
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            $display("mismatch at %0t: run did not finish", $time);
            test_done();
        end
    end

    function automatic logic [31:0] bv(input int b);
        return 32'h0000_0001 << b;
    endfunction

    // one classic cycle; entered just after a rising edge, leaves one idle cycle behind
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= be;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        if (n >= 50) begin
            error_cnt++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0000_0000, r);
    endtask

    // reads until the masked value does (eq=1) or does not (eq=0) equal v, bounded
    task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v,
                        input logic eq, output logic [31:0] r);
        int n;
        n = 0;
        do begin
            rd(a, r);
            n++;
        end while ((((r & m) === v) != eq) && n < 500);
        `CHK(((r & m) === v), eq)
    endtask

    task automatic ctl_wait(input logic [31:0] v, input int f);
        wr(wts_pkg::ADR_CONTROL, v);
        poll(wts_pkg::ADR_STATUS, bv(f), bv(f), 1'b1, q);
    endtask

    // readable registers, the reserved hole and a write-only place all read zero
    task automatic chk_zero();
        logic [31:0] a[7];
        a = '{wts_pkg::ADR_MODE, wts_pkg::ADR_STATUS, wts_pkg::ADR_IMR, wts_pkg::ADR_SECS,
              wts_pkg::ADR_ALARM, 32'hFFFA_4068, wts_pkg::ADR_CONTROL};
        foreach (a[i]) begin
            rd(a[i], q);
            `CHK(q, 32'h0000_0000);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_zero();
        wr(wts_pkg::ADR_MODE, 32'hFFFF_FFFF);
        rd(wts_pkg::ADR_MODE, q);
        `CHK(q, 32'h0000_0003);
        // both wrap limits, ticking from the divided master clock
        for (int w = 0; w < 2; w++) begin
            last = (w == 1) ? wts_pkg::LAST_FULL : wts_pkg::LAST_DAY;
            wr(wts_pkg::ADR_MODE, 32'h0000_0002 | 32'(w));
            wr(wts_pkg::ADR_SECS, last - 32'h0000_0001);
            rd(wts_pkg::ADR_STATUS, q);
            `CHK(q[wts_pkg::ST_WRITE_BUSY], 1'b1);
            poll(wts_pkg::ADR_STATUS, bv(wts_pkg::ST_WRITE_BUSY), 32'h0000_0000, 1'b1,
                 q);
            rd(wts_pkg::ADR_SECS, q);
            `CHK(q, last - 32'h0000_0001);
            ctl_wait(bv(wts_pkg::CTL_CNT_ON), wts_pkg::EV_CNT_ON);
            rd(wts_pkg::ADR_STATUS, q);
            `CHK(q[wts_pkg::ST_CNT_ENABLED], 1'b1);
            wr(wts_pkg::ADR_SECS, 32'h0000_1234);
            poll(wts_pkg::ADR_SECS, 32'hFFFF_FFFF, last, 1'b1, q);
            poll(wts_pkg::ADR_SECS, 32'hFFFF_FFFF, last, 1'b0, q);
            `CHK(q, 32'h0000_0000);
            ctl_wait(bv(wts_pkg::CTL_CNT_ON) | bv(wts_pkg::CTL_CNT_OFF),
                     wts_pkg::EV_CNT_OFF);
            rd(wts_pkg::ADR_STATUS, q);
            `CHK(q[wts_pkg::ST_CNT_ENABLED], 1'b0);
            wr(wts_pkg::ADR_CLEAR, 32'h0000_001F);
            rd(wts_pkg::ADR_STATUS, q);
            `CHK(q & 32'h0000_031F, 32'h0000_0000);
        end
        // oscillator ticks: four pulses from a load of zero
        wr(wts_pkg::ADR_MODE, 32'h0000_0000);
        wr(wts_pkg::ADR_SECS, 32'h0000_0000);
        poll(wts_pkg::ADR_STATUS, bv(wts_pkg::ST_WRITE_BUSY), 32'h0000_0000, 1'b1, q);
        ctl_wait(bv(wts_pkg::CTL_CNT_ON), wts_pkg::EV_CNT_ON);
        repeat (4) begin
            repeat (8) @(posedge clk_i);
            rt_oscillator_clock_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            rt_oscillator_clock_i <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        ctl_wait(bv(wts_pkg::CTL_CNT_OFF), wts_pkg::EV_CNT_OFF);
        rd(wts_pkg::ADR_SECS, q);
        `CHK(q, 32'h0000_0004);
        wr(wts_pkg::ADR_CLEAR, 32'h0000_001F);
        // stopped counter makes the stamp value known
        for (int ch = 0; ch < 16; ch += 5) begin
            can_frame_done_i <= 16'h0001 << ch;
            @(posedge clk_i);
            can_frame_done_i <= 16'h0000;
            #1;
            `CHK(can_stamp_we_o, 16'h0001 << ch);
            `CHK(can_stamp_o, 32'h0000_0004);
            @(posedge clk_i);
        end
        // alarm: day-limit refusal, write while enabled, match, mask and clear
        wr(wts_pkg::ADR_MODE, 32'h0000_0002);
        wr(wts_pkg::ADR_ALARM, wts_pkg::LAST_DAY);
        rd(wts_pkg::ADR_ALARM, q);
        `CHK(q, wts_pkg::LAST_DAY);
        wr(wts_pkg::ADR_ALARM, 32'h0000_0005);
        // byte lane 1 only: the other lanes keep the stored value
        be = 4'h2;
        wr(wts_pkg::ADR_ALARM, 32'hFFFF_03FF);
        be = 4'hF;
        rd(wts_pkg::ADR_ALARM, q);
        `CHK(q, 32'h0000_0305);
        wr(wts_pkg::ADR_ALARM, 32'h0000_0005);
        wr(wts_pkg::ADR_ALARM, wts_pkg::LIMIT_DAY);
        rd(wts_pkg::ADR_ALARM, q);
        `CHK(q, 32'h0000_0005);
        wr(wts_pkg::ADR_SECS, 32'h0000_0000);
        poll(wts_pkg::ADR_STATUS, bv(wts_pkg::ST_WRITE_BUSY), 32'h0000_0000, 1'b1, q);
        ctl_wait(bv(wts_pkg::CTL_ALM_ON), wts_pkg::EV_ALM_ON);
        rd(wts_pkg::ADR_STATUS, q);
        `CHK(q[wts_pkg::ST_ALM_ENABLED], 1'b1);
        wr(wts_pkg::ADR_ALARM, 32'h0000_0009);
        rd(wts_pkg::ADR_ALARM, q);
        `CHK(q, 32'h0000_0005);
        wr(wts_pkg::ADR_IER, bv(wts_pkg::EV_ALARM));
        rd(wts_pkg::ADR_IMR, q);
        `CHK(q, 32'h0000_0001);
        `CHK(irq_o, 1'b0);
        ctl_wait(bv(wts_pkg::CTL_CNT_ON), wts_pkg::EV_ALARM);
        rd(wts_pkg::ADR_SECS, q);
        `CHK((q >= 32'h0000_0005) && (q <= 32'h0000_0007), 1'b1);
        `CHK(irq_o, 1'b1);
        poll(wts_pkg::ADR_SECS, 32'hFFFF_FFFF, 32'h0000_0009, 1'b1, q);
        rd(wts_pkg::ADR_STATUS, q);
        `CHK(q[wts_pkg::EV_ALARM], 1'b1);
        wr(wts_pkg::ADR_IDR, bv(wts_pkg::EV_ALARM));
        rd(wts_pkg::ADR_IMR, q);
        `CHK(q, 32'h0000_0000);
        `CHK(irq_o, 1'b0);
        wr(wts_pkg::ADR_IER, bv(wts_pkg::EV_ALARM));
        `CHK(irq_o, 1'b1);
        wr(wts_pkg::ADR_CLEAR, bv(wts_pkg::EV_ALARM));
        `CHK(irq_o, 1'b0);
        rd(wts_pkg::ADR_STATUS, q);
        `CHK(q[wts_pkg::EV_ALARM], 1'b0);
        ctl_wait(bv(wts_pkg::CTL_ALM_ON) | bv(wts_pkg::CTL_ALM_OFF),
                 wts_pkg::EV_ALM_OFF);
        rd(wts_pkg::ADR_STATUS, q);
        `CHK(q[wts_pkg::ST_ALM_ENABLED], 1'b0);
        // soft reset: a zero write does nothing, a one clears everything
        wr(wts_pkg::ADR_CONTROL, 32'h0000_0000);
        rd(wts_pkg::ADR_MODE, q);
        `CHK(q, 32'h0000_0002);
        wr(wts_pkg::ADR_CONTROL, bv(wts_pkg::CTL_SOFT_RESET));
        repeat (2) @(posedge clk_i);
        chk_zero();
        `CHK(irq_o, 1'b0);
        test_done();
    end
endmodule // wts_watch_timer_tb
